// [rtl/softstart_regs.svh]
// Register offsets, field positions, reset values and timing counts.
`ifndef SOFTSTART_REGS_SVH
`define SOFTSTART_REGS_SVH

// Register byte offsets.
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_IRQ_STATUS 8'h08
`define REG_IRQ_MASK 8'h0c
`define REG_REFERENCE 8'h10

// Control register fields.
`define CTRL_RUN_BIT 0
`define CTRL_RESET_VALUE 32'h0000_0001

// Status register fields.
`define STATUS_STATE_LSB 0
`define STATUS_PG_BIT 4
`define STATUS_FAULT_BIT 5
`define STATUS_UV_EN_BIT 6
`define STATUS_PG_EN_BIT 7

// Interrupt event bits.
`define EV_RAMP_DONE 0
`define EV_UV_TRIP 1
`define EV_OV_TRIP 2
`define EV_SUPPLY_LOSS 3
`define EV_INHIBIT 4
`define EV_WIDTH 5
`define IRQ_MASK_RESET 5'h00

// Soft-start length in oscillator periods.
`define RAMP_PERIODS 2048
// Under-voltage trip enable level in millivolts (0.6 V).
`define UV_ENABLE_MV 600
// Window limits in percent.
`define PG_LOW_PCT 88
`define PG_HIGH_PCT 112
`define UV_PCT 60
`define OV_PCT 125

`endif

// [rtl/softstart_pkg.sv]
// Types shared by the soft-start sequencer.
package softstart_pkg;
   typedef enum logic [2:0] {
      s_off,
      s_ramp,
      s_run,
      s_fault_uv,
      s_fault_ov
   } seq_state_t;
endpackage : softstart_pkg

// [rtl/phase_pwm.sv]
// Two-phase PWM generator with phases 180 degrees apart.
`timescale 1ns/1ps
module phase_pwm
   #(parameter int PERIOD_W = 8)
   (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [PERIOD_W-1:0] period_i,
   input wire logic [PERIOD_W-1:0] duty_i,
   output logic osc_tick_o,
   output logic [1:0] pwm_o
   );

   logic [PERIOD_W-1:0] count;
   logic [PERIOD_W-1:0] half;

   assign half = period_i >> 1;

   // One count runs the oscillator; its wrap is the switching tick.
   always_ff @(posedge clk_i)
   begin
      if (rst_i || count >= period_i - 1'b1)
      begin
         count <= '0;
      end
      else
      begin
         count <= count + 1'b1;
      end
   end

   assign osc_tick_o = (count == '0);

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         pwm_o <= 2'b00;
      end
      else
      begin
         pwm_o[0] <= (count < duty_i);
         if (count >= half)
         begin
            pwm_o[1] <= ((count - half) < duty_i);
         end
         else
         begin
            pwm_o[1] <= ((count + (period_i - half)) < duty_i);
         end
      end
   end
endmodule : phase_pwm

// [rtl/window_compare.sv]
// Digital window comparator of the sensed output against references.
`timescale 1ns/1ps
module window_compare
   #(parameter int VW = 12)
   (
   input wire logic [VW-1:0] sense_i,
   input wire logic [VW-1:0] ramp_ref_i,
   input wire logic [VW-1:0] final_ref_i,
   output logic in_window_o,
   output logic under_o,
   output logic over_o
   );

   `include "softstart_regs.svh"

   function automatic logic [VW+7:0] pct(input logic [VW-1:0] v,
                                         input logic [7:0] p);
      pct = (VW+8)'(v) * (VW+8)'(p);
   endfunction : pct

   logic [VW+7:0] s100;

   assign s100 = (VW+8)'(sense_i) * (VW+8)'(100);
   assign in_window_o = (s100 >= pct(final_ref_i, 8'(`PG_LOW_PCT)))
      && (s100 <= pct(final_ref_i, 8'(`PG_HIGH_PCT)));
   assign under_o = s100 < pct(ramp_ref_i, 8'(`UV_PCT));
   assign over_o = s100 >= pct(final_ref_i, 8'(`OV_PCT));
endmodule : window_compare

// [rtl/softstart_seq.sv]
// Soft-start, inhibit and shutdown sequencer for a two-phase regulator.
// Summary of operation
// - Ramp reference from zero to code value over exactly 2048 periods.
// - Start switching both transistors of each phase when ramp starts.
// - After ramp ends enable power-good; drive it high in regulation.
// - Keep under-voltage trip off until reference reaches 0.6 V.
// - No soft-start unless both supplies exceed turn-on thresholds.
// - Shut down if either supply falls to under-voltage; in a latched over-voltage fault only the control supply does.
// - Enable low turns off transistors and protections until released, except in a latched over-voltage fault.
// - On power-down regulate until control supply is below threshold.
// - Drive the two phases 180 degrees apart.
// - Power-good low in soft-start, then low outside 12 percent window.
// - Output below 60 percent for over one period latches a fault.
// - Output at 125 percent: low sides on, high sides off, latched.
// - Under-voltage from ramping reference, over-voltage from final one.
//
// Added by the designer: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
module softstart_seq
   import softstart_pkg::*;
   #(parameter int VW = 12,
     parameter int CODE_W = 6,
     parameter int PERIOD_W = 8,
     parameter int RAMP_W = 11,
     parameter logic [VW-1:0] REF_BASE_MV = 12'd800,
     parameter logic [VW-1:0] REF_STEP_MV = 12'd12,
     parameter logic [PERIOD_W-1:0] OSC_PERIOD = 8'd100)
   (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [7:0] adr_i,
   input wire logic [31:0] dat_i,
   input wire logic [3:0] sel_i,
   input wire logic we_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   output logic irq_o,
   input wire logic ctrl_supply_ok_i,
   input wire logic driver_supply_ok_i,
   input wire logic output_enable_input_i,
   input wire logic [CODE_W-1:0] voltage_code_inputs_i,
   input wire logic [VW-1:0] sensed_output_voltage_i,
   input wire logic [PERIOD_W-1:0] duty_i,
   output logic [1:0] high_side_o,
   output logic [1:0] low_side_o,
   output logic regulation_ok_output_o,
   output logic regulation_ok_output_oe_o,
   output logic fault_indicator_output_o
   );

   `include "softstart_regs.svh"

   ////////////////////////////////////////////////////////////////////
   // Pin synchronisers.
   logic [3:0] pin_meta;
   logic [3:0] pin_sync;
   logic [CODE_W-1:0] code_meta;
   logic [CODE_W-1:0] code_sync;
   logic [VW-1:0] sense_meta;
   logic [VW-1:0] sense_sync;

   always_ff @(posedge clk_i)
   begin
      pin_meta <= {output_enable_input_i, driver_supply_ok_i,
                   ctrl_supply_ok_i, 1'b0};
      pin_sync <= pin_meta;
      code_meta <= voltage_code_inputs_i;
      code_sync <= code_meta;
      sense_meta <= sensed_output_voltage_i;
      sense_sync <= sense_meta;
   end

   logic ctrl_ok;
   logic drv_ok;
   logic enable_in;

   assign ctrl_ok = pin_sync[1];
   assign drv_ok = pin_sync[2];
   assign enable_in = pin_sync[3];

   ////////////////////////////////////////////////////////////////////
   // Oscillator, PWM and comparators.
   logic osc_tick;
   logic [1:0] pwm;
   logic in_window;
   logic under;
   logic over;
   logic [VW-1:0] final_ref;
   logic [VW-1:0] ramp_ref;
   logic [RAMP_W:0] ramp_count;
   seq_state_t state;
   logic run_en;

   phase_pwm #(.PERIOD_W(PERIOD_W)) u_pwm (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .period_i(OSC_PERIOD),
      .duty_i(duty_i),
      .osc_tick_o(osc_tick),
      .pwm_o(pwm)
   );

   window_compare #(.VW(VW)) u_cmp (
      .sense_i(sense_sync),
      .ramp_ref_i(ramp_ref),
      .final_ref_i(final_ref),
      .in_window_o(in_window),
      .under_o(under),
      .over_o(over)
   );

   function automatic logic [VW-1:0] code_to_mv(input logic [CODE_W-1:0] c);
      code_to_mv = REF_BASE_MV + VW'(c) * REF_STEP_MV;
   endfunction : code_to_mv

   assign final_ref = code_to_mv(code_sync);

   assign ramp_ref = (state == s_ramp) ?
      VW'(((VW+RAMP_W+1)'(final_ref) * (VW+RAMP_W+1)'(ramp_count))
          >> RAMP_W) :
      ((state == s_run) ? final_ref : '0);

   logic supplies_ok;
   logic inhibit;
   logic uv_enable;
   logic pg_enable;
   logic uv_pending;

   assign supplies_ok = ctrl_ok && drv_ok;
   assign inhibit = !enable_in;
   assign uv_enable = (state == s_run) ||
      ((state == s_ramp) && (ramp_ref >= VW'(`UV_ENABLE_MV)));
   assign pg_enable = (state == s_run);

   ////////////////////////////////////////////////////////////////////
   // Sequencer state.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state <= s_off;
      end
      else
      begin
         case (state)
            s_off:
            begin
               if (supplies_ok && !inhibit && run_en)
               begin
                  state <= s_ramp;
               end
            end
            s_ramp, s_run:
            begin
               if (!inhibit && over)
               begin
                  state <= s_fault_ov;
               end
               else if (!inhibit && uv_enable && under && uv_pending
                        && osc_tick)
               begin
                  state <= s_fault_uv;
               end
               else if (!supplies_ok || inhibit || !run_en)
               begin
                  state <= s_off;
               end
               else if (state == s_ramp && osc_tick &&
                        ramp_count == (RAMP_W+1)'(`RAMP_PERIODS - 1))
               begin
                  state <= s_run;
               end
            end
            default:
            begin
               // Latched faults clear only when the control supply drops.
               if (!ctrl_ok)
               begin
                  state <= s_off;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i || state != s_ramp)
      begin
         ramp_count <= '0;
      end
      else if (osc_tick)
      begin
         ramp_count <= ramp_count + 1'b1;
      end
   end

   // Under-voltage must persist past one full oscillator period.
   always_ff @(posedge clk_i)
   begin
      if (rst_i || !under || !uv_enable)
      begin
         uv_pending <= 1'b0;
      end
      else if (osc_tick)
      begin
         uv_pending <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Gate drive and status pins.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         high_side_o <= 2'b00;
         low_side_o <= 2'b00;
      end
      else if (state == s_fault_ov)
      begin
         high_side_o <= 2'b00;
         low_side_o <= 2'b11;
      end
      else if (state == s_ramp || state == s_run)
      begin
         high_side_o <= pwm;
         low_side_o <= ~pwm;
      end
      else
      begin
         high_side_o <= 2'b00;
         low_side_o <= 2'b00;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         regulation_ok_output_o <= 1'b0;
         regulation_ok_output_oe_o <= 1'b1;
         fault_indicator_output_o <= 1'b0;
      end
      else
      begin
         regulation_ok_output_o <= 1'b0;
         regulation_ok_output_oe_o <= !(pg_enable && in_window);
         fault_indicator_output_o <= (state == s_fault_uv) ||
                                     (state == s_fault_ov);
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Interrupt status and Wishbone slave.
   logic [`EV_WIDTH-1:0] events;
   logic [`EV_WIDTH-1:0] irq_status;
   logic [`EV_WIDTH-1:0] irq_mask;
   logic prev_supplies;
   logic prev_inhibit;
   logic [31:0] next_dat;
   logic bus_req;
   logic rd_status;

   assign bus_req = cyc_i && stb_i && !ack_o;
   assign rd_status = bus_req && !we_i && adr_i == `REG_IRQ_STATUS;

   always_ff @(posedge clk_i)
   begin
      prev_supplies <= rst_i ? 1'b0 : supplies_ok;
      prev_inhibit <= rst_i ? 1'b0 : inhibit;
   end

   always_comb
   begin
      events = '0;
      events[`EV_RAMP_DONE] = (state == s_ramp) && osc_tick &&
         ramp_count == (RAMP_W+1)'(`RAMP_PERIODS - 1);
      events[`EV_UV_TRIP] = (state == s_fault_uv) && (ramp_count == '0)
         && !fault_indicator_output_o;
      events[`EV_OV_TRIP] = (state == s_fault_ov) &&
         !fault_indicator_output_o;
      events[`EV_SUPPLY_LOSS] = prev_supplies && !supplies_ok;
      events[`EV_INHIBIT] = !prev_inhibit && inhibit;
   end

   // A new event in the clearing read's cycle stays set.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         irq_status <= '0;
      end
      else
      begin
         irq_status <= (rd_status ? '0 : irq_status) | events;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         irq_o <= 1'b0;
      end
      else
      begin
         irq_o <= |(irq_status & irq_mask);
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         run_en <= 1'(`CTRL_RESET_VALUE >> `CTRL_RUN_BIT);
         irq_mask <= `IRQ_MASK_RESET;
      end
      else if (bus_req && we_i && sel_i[0])
      begin
         if (adr_i == `REG_CTRL)
         begin
            run_en <= dat_i[`CTRL_RUN_BIT];
         end
         else if (adr_i == `REG_IRQ_MASK)
         begin
            irq_mask <= dat_i[`EV_WIDTH-1:0];
         end
      end
   end

   always_comb
   begin
      next_dat = 32'h0000_0000;
      if (adr_i == `REG_CTRL)
      begin
         next_dat[`CTRL_RUN_BIT] = run_en;
      end
      else if (adr_i == `REG_STATUS)
      begin
         next_dat[`STATUS_STATE_LSB +: 3] = state;
         next_dat[`STATUS_PG_BIT] = !regulation_ok_output_oe_o;
         next_dat[`STATUS_FAULT_BIT] = fault_indicator_output_o;
         next_dat[`STATUS_UV_EN_BIT] = uv_enable;
         next_dat[`STATUS_PG_EN_BIT] = pg_enable;
      end
      else if (adr_i == `REG_IRQ_STATUS)
      begin
         next_dat[`EV_WIDTH-1:0] = irq_status;
      end
      else if (adr_i == `REG_IRQ_MASK)
      begin
         next_dat[`EV_WIDTH-1:0] = irq_mask;
      end
      else if (adr_i == `REG_REFERENCE)
      begin
         next_dat[VW-1:0] = ramp_ref;
      end
   end

   // Unmapped addresses still ack and read as zero.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ack_o <= 1'b0;
         dat_o <= 32'h0000_0000;
      end
      else
      begin
         ack_o <= bus_req;
         dat_o <= bus_req ? next_dat : 32'h0000_0000;
      end
   end
endmodule : softstart_seq

// [tb/softstart_seq_props.sv]
// Port-level assertions for the soft-start sequencer.
`timescale 1ns/1ps
module softstart_seq_props
   (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [7:0] adr_i,
   input wire logic we_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic [31:0] dat_o,
   input wire logic ack_o,
   input wire logic ctrl_supply_ok_i,
   input wire logic driver_supply_ok_i,
   input wire logic output_enable_input_i,
   input wire logic [1:0] high_side_o,
   input wire logic [1:0] low_side_o,
   input wire logic regulation_ok_output_oe_o,
   input wire logic fault_indicator_output_o
   );
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   property p_ack_pulse;
      ack_o |=> !ack_o;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse)
      else $error("ack longer than one cycle");
   property p_ack_cause;
      ack_o |-> $past(cyc_i && stb_i);
   endproperty
   a_ack_cause: assert property (p_ack_cause)
      else $error("ack without a request");
   property p_unmapped;
      ack_o && $past(!we_i && adr_i > 8'h10) |-> dat_o == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped read not zero");
   property p_inhibit_off;
      !output_enable_input_i [*6] |-> high_side_o == 2'b00;
   endproperty
   a_inhibit_off: assert property (p_inhibit_off)
      else $error("high side on while inhibited");
   property p_inhibit_pg;
      !output_enable_input_i [*6] |-> regulation_ok_output_oe_o;
   endproperty
   a_inhibit_pg: assert property (p_inhibit_pg)
      else $error("power good released while inhibited");
   property p_ctrl_off;
      !ctrl_supply_ok_i [*6] |-> (high_side_o | low_side_o) == 2'b00;
   endproperty
   a_ctrl_off: assert property (p_ctrl_off)
      else $error("gates on without control supply");
   property p_drv_off;
      !driver_supply_ok_i [*6] |-> high_side_o == 2'b00;
   endproperty
   a_drv_off: assert property (p_drv_off)
      else $error("high side on without driver supply");
   property p_fault_gates;
      fault_indicator_output_o |=> high_side_o == 2'b00;
   endproperty
   a_fault_gates: assert property (p_fault_gates)
      else $error("high side on during fault");
   property p_fault_latch;
      fault_indicator_output_o && ctrl_supply_ok_i && $past(ctrl_supply_ok_i)
         && $past(ctrl_supply_ok_i, 3) |=> fault_indicator_output_o;
   endproperty
   a_fault_latch: assert property (p_fault_latch)
      else $error("fault cleared with supply up");
endmodule : softstart_seq_props

bind softstart_seq softstart_seq_props chk (.clk_i, .rst_i, .adr_i, .we_i,
   .cyc_i, .stb_i, .dat_o, .ack_o, .ctrl_supply_ok_i, .driver_supply_ok_i,
   .output_enable_input_i, .high_side_o, .low_side_o,
   .regulation_ok_output_oe_o, .fault_indicator_output_o);

// [tb/power_stage_model.sv]
// Power stage, output filter and power-good pull-up of the board.
`timescale 1ns/1ps
module power_stage_model
   (
   input wire logic clk_i,
   input wire logic [1:0] high_side_i,
   input wire logic [1:0] low_side_i,
   input wire logic pg_oe_i,
   input wire logic [11:0] target_i,
   output logic [11:0] sense_o,
   output logic pg_pin_o
   );
   logic [3:0] idle = 4'hf;
   // driven output
   // The output holds while some transistor is driven and collapses 15 cycles after the last one.
   always_ff @(posedge clk_i)
   begin
      if ((high_side_i | low_side_i) != 2'b00)
         idle <= 4'h0;
      else if (idle != 4'hf)
         idle <= idle + 4'h1;
   end
   assign sense_o = (idle == 4'hf) ? 12'h000 : target_i;
   assign pg_pin_o = !pg_oe_i;
endmodule : power_stage_model

// [tb/softstart_seq_tb.sv]
// Self-checking bench for the soft-start sequencer.
`timescale 1ns/1ps
module softstart_seq_tb;
   localparam int VREF = 800 + 12 * 42;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [7:0] adr_i = 8'h00;
   logic [31:0] dat_i = 32'h0;
   logic [3:0] sel_i = 4'h0;
   logic we_i = 1'b0;
   logic cyc_i = 1'b0;
   logic stb_i = 1'b0;
   logic c_ok = 1'b0;
   logic d_ok = 1'b0;
   logic en = 1'b1;
   logic [11:0] target = 12'(VREF);
   logic [31:0] dat_o, rd;
   logic ack_o, irq_o, pg, pg_oe, fault, pin;
   logic [1:0] hs, ls;
   logic [11:0] sense;
   logic [3:0] sw;
   int n_errors = 0;
   int checked = 0;
   int i;

   softstart_seq #(.OSC_PERIOD(8'h04)) DUT (.clk_i, .rst_i, .adr_i, .dat_i,
      .sel_i, .we_i, .cyc_i, .stb_i, .dat_o, .ack_o, .irq_o,
      .ctrl_supply_ok_i(c_ok), .driver_supply_ok_i(d_ok),
      .output_enable_input_i(en), .voltage_code_inputs_i(6'h2a),
      .sensed_output_voltage_i(sense), .duty_i(8'h01), .high_side_o(hs),
      .low_side_o(ls), .regulation_ok_output_o(pg),
      .regulation_ok_output_oe_o(pg_oe), .fault_indicator_output_o(fault));
   power_stage_model board (.clk_i, .high_side_i(hs), .low_side_i(ls),
      .pg_oe_i(pg_oe), .target_i(target), .sense_o(sense), .pg_pin_o(pin));

   initial
   begin
      forever #2 clk_i = ~clk_i;
   end

   task automatic chk(input logic [31:0] g, input logic [31:0] e,
         input string s);
      checked++;
      if (g !== e)
      begin
         n_errors++;
         $display("CHECK FAILED at %0t: %s got %h want %h", $time, s, g, e);
      end
   endtask : chk

   // Classic single cycle; waits for ack, bounded.
   task automatic bus(input logic w, input logic [7:0] a,
         input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= d;
      sel_i <= 4'hf;
      @(posedge clk_i);
      while (ack_o !== 1'b1 && n < 20)
      begin
         @(posedge clk_i);
         n++;
      end
      rd = dat_o;
      if (n == 20)
         chk(0, 1, "bus timeout");
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
   endtask : bus

   task automatic rdchk(input logic [7:0] a, input logic [31:0] m,
         input logic [31:0] e, input string s);
      bus(1'b0, a, 32'h0);
      chk(rd & m, e, s);
   endtask : rdchk

   task automatic wait_state(input logic [2:0] want, input int tries);
      for (int k = 0; k < tries; k++)
      begin
         bus(1'b0, 8'h04, 32'h0);
         if (rd[2:0] === want)
            break;
      end
      chk(rd & 32'h7, {29'h0, want}, "state");
   endtask : wait_state

   task automatic wrap_up;
      $display("checks %0d errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : wrap_up

   initial
   begin
      // Three full ramps of about 8200 cycles each plus checks fit easily.
      #240000;
      n_errors++;
      wrap_up();
   end

   initial
   begin
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      rdchk(8'h00, 32'h1, 32'h1, "ctrl reset");
      rdchk(8'h0c, 32'h1f, 32'h0, "mask reset");
      bus(1'b1, 8'h14, 32'hffff_ffff);
      rdchk(8'h14, 32'hffff_ffff, 32'h0, "unmapped");
      c_ok <= 1'b1;
      repeat (40) @(posedge clk_i);
      rdchk(8'h04, 32'h7, 32'h0, "no start");
      rdchk(8'h10, 32'hfff, 32'h0, "ref zero");
      chk({30'h0, hs | ls}, 32'h0, "gates idle");
      $display("idle test done");
      d_ok <= 1'b1;
      wait_state(3'h1, 20);
      rdchk(8'h04, 32'hc0, 32'h0, "early enables");
      chk(pg_oe, 1'b1, "pg low in ramp");
      sw = 4'h0;
      repeat (20) @(posedge clk_i) sw |= {hs, ls};
      chk(sw, 4'hf, "switching");
      while (hs !== 2'b01) @(posedge clk_i);
      i = 0;
      while (hs[1] !== 1'b1 && i < 9)
      begin
         @(posedge clk_i);
         i++;
      end
      chk(i, 2, "phase offset");
      repeat (2048 * 4 - 100) @(posedge clk_i);
      rdchk(8'h04, 32'h7, 32'h1, "still ramping");
      wait_state(3'h2, 40);
      rdchk(8'h10, 32'hfff, VREF, "final ref");
      rdchk(8'h04, 32'hc0, 32'hc0, "enables");
      chk({pg_oe, pin}, 2'b01, "pg high");
      chk(irq_o, 1'b0, "irq masked");
      bus(1'b1, 8'h0c, 32'h1f);
      repeat (3) @(posedge clk_i);
      chk(irq_o, 1'b1, "irq raised");
      rdchk(8'h08, 32'h1, 32'h1, "ramp event");
      repeat (3) @(posedge clk_i);
      chk(irq_o, 1'b0, "irq cleared");
      $display("ramp test done");
      target <= 12'(VREF * 115 / 100);
      repeat (10) @(posedge clk_i);
      chk(pg_oe, 1'b1, "pg out of window");
      target <= 12'(VREF);
      repeat (10) @(posedge clk_i);
      chk(pg_oe, 1'b0, "pg back");
      en <= 1'b0;
      repeat (10) @(posedge clk_i);
      chk({30'h0, hs | ls}, 32'h0, "inhibit gates");
      rdchk(8'h10, 32'hfff, 32'h0, "ref cleared");
      rdchk(8'h08, 32'h10, 32'h10, "inhibit event");
      en <= 1'b1;
      wait_state(3'h1, 20);
      wait_state(3'h2, 2800);
      $display("inhibit test done");
      target <= 12'h1f4;
      repeat (20) @(posedge clk_i);
      chk({fault, hs, ls}, 5'h10, "uv trip");
      target <= 12'(VREF);
      repeat (20) @(posedge clk_i);
      rdchk(8'h04, 32'h27, 32'h23, "uv latched");
      c_ok <= 1'b0;
      repeat (10) @(posedge clk_i);
      chk({fault, hs, ls}, 5'h0, "power down");
      c_ok <= 1'b1;
      wait_state(3'h1, 20);
      d_ok <= 1'b0;
      repeat (10) @(posedge clk_i);
      rdchk(8'h04, 32'h7, 32'h0, "driver loss");
      d_ok <= 1'b1;
      wait_state(3'h1, 20);
      wait_state(3'h2, 2800);
      target <= 12'(VREF * 125 / 100);
      repeat (10) @(posedge clk_i);
      chk({fault, hs, ls}, 5'h13, "ov crowbar");
      rdchk(8'h04, 32'h27, 32'h24, "ov latched");
      $display("fault test done");
      wrap_up();
   end
endmodule : softstart_seq_tb
